/* File: src/gpmux_top.sv */
// Output control for general pin five: control register and pin driver.
// Assumes routed status inputs are synchronous to clk_sys_i; the
// register port follows the plain strobe protocol with read data one
// cycle after the read strobe.
//
// Function
// - Source field bits 4:2 picks receive port 0-3, device status, or transmit port.
// - Select field bits 7:5 is decoded per source; both fields reset to zero.
// - Receive source, select 0 and 1 drive remote pins 0 and 1.
// - Receive source, select 2 and 3 drive remote pins 2 and 3.
// - Receive source, select 4-7 drive lock, pass, frame valid, line valid.
// - Status source maps local value, lock OR, pass AND, frame sync; rest reserved.
// - Transmit source maps pass AND/OR, frame, line, synchronized, interrupt.
// - Bit 1 holds the local value, driven when that source is chosen.
// - Bit 0 enables the output driver; zero leaves it disabled.
module gpmux_top
    import gpmux_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [7:0] reg_rdata_o,
    input wire gpmux_rx_status_t [GPMUX_NUM_RX-1:0] rx_status_i,
    input wire logic [GPMUX_NUM_RX-1:0] rx_enabled_i,
    input wire logic frame_sync_pulse_i,
    input wire gpmux_tx_status_t tx_status_i,
    output logic general_pin_five_o,
    output logic general_pin_five_oe_o
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    // The asynchronous reset is released through two flops so that all
    // state leaves reset on the same edge.
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Control register and read port
    // ------------------------------------------------------------------
    gpmux_ctrl_t ctrl_q;
    gpmux_ctrl_t ctrl_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb begin
        ctrl_d = ctrl_q;
        rdata_d = 8'h00;
        if (reg_write_i && reg_addr_i == GPMUX_ADDR_PIN5_CTRL) begin
            ctrl_d = gpmux_ctrl_t'(reg_wdata_i);
        end
        // Unmapped addresses read as zero.
        if (reg_read_i && reg_addr_i == GPMUX_ADDR_PIN5_CTRL) begin
            rdata_d = ctrl_q;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ctrl_q <= gpmux_ctrl_t'(GPMUX_CTRL_RESET);
            rdata_q <= 8'h00;
        end else if (clk_en_i) begin
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

    // ------------------------------------------------------------------
    // Pin data selection and output stage
    // ------------------------------------------------------------------
    logic pin_data;
    logic pin_q;
    logic pin_d;
    logic oe_q;
    logic oe_d;

    gpmux_select u_select (
        .ctrl_i(ctrl_q),
        .rx_i(rx_status_i),
        .rx_enabled_i(rx_enabled_i),
        .frame_sync_pulse_i(frame_sync_pulse_i),
        .tx_i(tx_status_i),
        .data_o(pin_data)
    );

    // Data is held low while the driver is off so the pin shows no
    // stale value when enable returns.
    always_comb begin
        oe_d = ctrl_q.drive_enable;
        pin_d = ctrl_q.drive_enable & pin_data;
    end

    always_ff @(posedge clk_sys_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            pin_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (clk_en_i) begin
            pin_q <= pin_d;
            oe_q <= oe_d;
        end
    end

    assign general_pin_five_o = pin_q;
    assign general_pin_five_oe_o = oe_q;

endmodule : gpmux_top

/* File: src/gpmux_pkg.sv */
// Package for the general pin five output multiplexer.
// Assumes a plain register port with an 8-bit address and 8-bit data.
package gpmux_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] GPMUX_ADDR_PIN5_CTRL = 8'h15;
    localparam logic [7:0] GPMUX_CTRL_RESET = 8'h00;
    localparam int GPMUX_EN_BIT = 0;
    localparam int GPMUX_VAL_BIT = 1;
    localparam int GPMUX_SRC_LSB = 2;
    localparam int GPMUX_SEL_LSB = 5;
    localparam int GPMUX_NUM_RX = 4;

    // ------------------------------------------------------------------
    // Source group codes
    // ------------------------------------------------------------------
    localparam logic [2:0] GPMUX_SRC_STATUS = 3'h4;
    localparam logic [2:0] GPMUX_SRC_TX0 = 3'h6;

    // Per-receive-port signals routed to the pin.
    typedef struct packed {
        logic [3:0] remote_pin;
        logic lock;
        logic pass;
        logic frame_valid;
        logic line_valid;
    } gpmux_rx_status_t;

    // Transmit port and device-wide signals.
    typedef struct packed {
        logic pass_and;
        logic pass_or;
        logic frame_sending;
        logic line_sending;
        logic synchronized;
        logic tx_interrupt;
    } gpmux_tx_status_t;

    // Decoded control register.
    typedef struct packed {
        logic [2:0] signal_select;
        logic [2:0] source_group;
        logic local_value;
        logic drive_enable;
    } gpmux_ctrl_t;

endpackage : gpmux_pkg

/* File: src/gpmux_select.sv */
// Combinational selector for the pin five data source.
// Assumes all inputs are already on the system clock.
module gpmux_select
    import gpmux_pkg::*;
(
    input wire gpmux_ctrl_t ctrl_i,
    input wire gpmux_rx_status_t [GPMUX_NUM_RX-1:0] rx_i,
    input wire logic [GPMUX_NUM_RX-1:0] rx_enabled_i,
    input wire logic frame_sync_pulse_i,
    input wire gpmux_tx_status_t tx_i,
    output logic data_o
);

    gpmux_rx_status_t rx_sel;
    logic lock_or;
    logic pass_and;

    // ------------------------------------------------------------------
    // Device-wide reductions
    // ------------------------------------------------------------------
    always_comb begin
        lock_or = 1'b0;
        pass_and = 1'b1;
        for (int i = 0; i < GPMUX_NUM_RX; i++) begin
            if (rx_enabled_i[i]) begin
                lock_or = lock_or | rx_i[i].lock;
                pass_and = pass_and & rx_i[i].pass;
            end
        end
    end

    // ------------------------------------------------------------------
    // Source and select decode
    // ------------------------------------------------------------------
    always_comb begin
        rx_sel = rx_i[ctrl_i.source_group[1:0]];
        data_o = 1'b0;
        if (ctrl_i.source_group[2] == 1'b0) begin
            case (ctrl_i.signal_select)
                3'h0: data_o = rx_sel.remote_pin[0];
                3'h1: data_o = rx_sel.remote_pin[1];
                3'h2: data_o = rx_sel.remote_pin[2];
                3'h3: data_o = rx_sel.remote_pin[3];
                3'h4: data_o = rx_sel.lock;
                3'h5: data_o = rx_sel.pass;
                3'h6: data_o = rx_sel.frame_valid;
                default: data_o = rx_sel.line_valid;
            endcase
        end else if (ctrl_i.source_group == GPMUX_SRC_STATUS) begin
            case (ctrl_i.signal_select)
                3'h0: data_o = ctrl_i.local_value;
                3'h1: data_o = lock_or;
                3'h2: data_o = pass_and;
                3'h3: data_o = pass_and;
                3'h4: data_o = frame_sync_pulse_i;
                default: data_o = 1'b0;
            endcase
        end else if (ctrl_i.source_group == GPMUX_SRC_TX0) begin
            case (ctrl_i.signal_select)
                3'h0: data_o = tx_i.pass_and;
                3'h1: data_o = tx_i.pass_or;
                3'h2: data_o = tx_i.frame_sending;
                3'h3: data_o = tx_i.line_sending;
                3'h4: data_o = tx_i.synchronized;
                3'h5: data_o = tx_i.tx_interrupt;
                default: data_o = 1'b0;
            endcase
        end
    end

endmodule : gpmux_select

/* File: sim/gpmux_monitor.sv */
// Checker for the pin five output multiplexer.
// Assumes it is bound to gpmux_top and sees only that module's ports.
module gpmux_monitor
    import gpmux_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [7:0] reg_rdata_o,
    input wire gpmux_rx_status_t [GPMUX_NUM_RX-1:0] rx_status_i,
    input wire logic [GPMUX_NUM_RX-1:0] rx_enabled_i,
    input wire logic frame_sync_pulse_i,
    input wire gpmux_tx_status_t tx_status_i,
    input wire logic general_pin_five_o,
    input wire logic general_pin_five_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh_q;
    logic [2:0] src;
    logic [2:0] sel;
    logic live;
    logic pin;
    logic [3:0] lock_v;
    logic [3:0] pass_v;
    // The control register is not a port, so it is rebuilt from the writes seen.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) sh_q <= 8'h00;
        else if (clk_en_i && reg_write_i && reg_addr_i == GPMUX_ADDR_PIN5_CTRL) sh_q <= reg_wdata_i;
    end
    assign src = sh_q[4:2];
    assign sel = sh_q[7:5];
    assign live = clk_en_i && sh_q[0];
    assign pin = general_pin_five_o;
    always_comb begin
        for (int i = 0; i < GPMUX_NUM_RX; i++) begin
            lock_v[i] = rx_status_i[i].lock;
            pass_v[i] = rx_status_i[i].pass;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    en_drive_a: assert property (clk_en_i |=> general_pin_five_oe_o == $past(sh_q[0]))
        else $error("enable mismatch");
    off_low_a: assert property (clk_en_i && !sh_q[0] |=> !pin)
        else $error("pin high while off");
    local_val_a: assert property (live && src == 3'h4 && sel == 3'h0 |=> pin == $past(sh_q[1]))
        else $error("local value mismatch");
    rx_pin_a: assert property (live && !src[2] && !sel[2]
        |=> pin == $past(rx_status_i[src[1:0]].remote_pin[sel[1:0]])) else $error("remote pin");
    rx_flag_a: assert property (live && !src[2] && sel[2]
        |=> pin == $past(rx_status_i[src[1:0]][3 - sel[1:0]])) else $error("port flag");
    stat_or_a: assert property (live && src == 3'h4 && sel == 3'h1
        |=> pin == $past(|(lock_v & rx_enabled_i))) else $error("lock or");
    stat_and_a: assert property (live && src == 3'h4 && sel[2:1] == 2'h1
        |=> pin == $past(&(pass_v | ~rx_enabled_i))) else $error("pass and");
    tx_map_a: assert property (live && src == GPMUX_SRC_TX0 && sel < 3'h6
        |=> pin == $past(tx_status_i[5 - sel])) else $error("transmit map");
    resv_low_a: assert property (live && (src[0] && src[2] || src == GPMUX_SRC_STATUS && sel > 3'h4
        || src == GPMUX_SRC_TX0 && sel > 3'h5) |=> !pin) else $error("reserved not low");
    rd_back_a: assert property (clk_en_i && reg_read_i
        |=> reg_rdata_o == ($past(reg_addr_i) == GPMUX_ADDR_PIN5_CTRL ? $past(sh_q) : 8'h00))
        else $error("rdata");
    cover property (live && src == GPMUX_SRC_TX0);
    cover property (live && src == 3'h5);
    cover property (reg_read_i && reg_addr_i != GPMUX_ADDR_PIN5_CTRL);
endmodule : gpmux_monitor

bind gpmux_top gpmux_monitor mon (.clk_sys_i, .rst_n_i, .clk_en_i, .reg_addr_i, .reg_wdata_i,
    .reg_write_i, .reg_read_i, .reg_rdata_o, .rx_status_i, .rx_enabled_i, .frame_sync_pulse_i,
    .tx_status_i, .general_pin_five_o, .general_pin_five_oe_o);

/* File: sim/gpmux_pin_sink.sv */
// Model of the external logic that reads general pin five.
// Assumes a board pull-down, so an undriven pin reads low.
module gpmux_pin_sink (
    input wire logic pin_i,
    input wire logic oe_i,
    output logic level_o
);
    timeunit 1ns;
    timeprecision 1ns;
    assign level_o = oe_i ? pin_i : 1'b0;
endmodule : gpmux_pin_sink

/* File: sim/gpmux_top_tb.sv */
// Testbench for the pin five output multiplexer.
// Assumes the register port and the pin sink model; expected pin levels come from ref_bit.
module gpmux_top_tb
    import gpmux_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] CTRL = GPMUX_ADDR_PIN5_CTRL;
    logic clk = 1'b0;
    logic rst_n, ce, we, re, fs, pin, oe, lvl;
    logic [7:0] addr, wd, rd, ctl;
    logic [31:0] rxv;
    logic [3:0] ren;
    logic [5:0] tx;
    int err_total = 0;
    int n_checks = 0;
    gpmux_top dut (.clk_sys_i(clk), .rst_n_i(rst_n), .clk_en_i(ce), .reg_addr_i(addr),
        .reg_wdata_i(wd), .reg_write_i(we), .reg_read_i(re), .reg_rdata_o(rd), .rx_status_i(rxv),
        .rx_enabled_i(ren), .frame_sync_pulse_i(fs), .tx_status_i(tx),
        .general_pin_five_o(pin), .general_pin_five_oe_o(oe));
    gpmux_pin_sink sink (.pin_i(pin), .oe_i(oe), .level_o(lvl));
    always #5 clk = ~clk;
    function automatic logic ref_bit(input logic [7:0] c);
        logic [2:0] s;
        logic [2:0] g;
        s = c[7:5];
        g = c[4:2];
        if (!c[0]) return 1'b0;
        if (!g[2]) return rxv[g[1:0] * 8 + (s[2] ? 7 - s : 4 + s)];
        if (g == 3'h4) begin
            case (s)
                3'h0: return c[1];
                3'h1: return |({rxv[27], rxv[19], rxv[11], rxv[3]} & ren);
                3'h2, 3'h3: return &({rxv[26], rxv[18], rxv[10], rxv[2]} | ~ren);
                3'h4: return fs;
                default: return 1'b0;
            endcase
        end
        if (g == 3'h6 && s < 3'h6) return tx[5 - s];
        return 1'b0;
    endfunction : ref_bit
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Write then read back at once, so every step also tests back-to-back strobes.
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic c, input logic [7:0] ra);
        addr <= a;
        wd <= d;
        we <= 1'b1;
        ce <= c;
        @(posedge clk);
        we <= 1'b0;
        ce <= 1'b1;
        addr <= ra;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        if (c && a == CTRL) ctl = d;
        #1;
        chk("read data", ra == CTRL ? ctl : 8'h00, rd);
        @(posedge clk);
        #1;
        chk("pin level", ref_bit(ctl), lvl);
        chk("output enable", ctl[0], oe);
        chk("pin data", ref_bit(ctl), pin);
        @(posedge clk);
    endtask : acc
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    initial begin
        {rst_n, ce, addr, wd, we, re, rxv, ren, fs, tx} = '0;
        ctl = 8'h00;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        acc(8'h14, 8'hFF, 1'b1, CTRL);
        // Input sets alternate polarity and include the case with no port enabled.
        for (int k = 0; k < 4; k++) begin
            rxv <= 32'h5AC3_9E17 ^ {32{k[0]}};
            ren <= 4'(16'hAF50 >> (4 * k));
            fs <= k[0];
            tx <= 6'h2D ^ {6{k[0]}};
            for (int c = 0; c < 256; c++) begin
                acc(CTRL, 8'(c), 1'b1, CTRL);
            end
        end
        acc(CTRL, 8'h00, 1'b0, 8'h14);
        give_verdict();
    end
    initial begin
        #200_000;
        err_total++;
        give_verdict();
    end
endmodule : gpmux_top_tb
